// [frtcc_timer.v]
// Free-running timer with two compare channels and one capture channel.
`include "frtcc_defs.vh"
module frtcc_timer (
	input  wire        clk,                // System clock, 50 MHz.
	input  wire        arst_n,             // Asynchronous reset, active low.
	input  wire        standby,            // High while a standby mode is held.
	input  wire [15:0] addr,               // Processor byte address.
	input  wire        rd_en,              // Read strobe, one cycle per byte.
	input  wire        wr_en,              // Write strobe, one cycle per byte.
	input  wire [7:0]  wdata,              // Write data byte.
	output reg  [7:0]  rdata_r,            // Read data, valid the cycle after rd_en.
	input  wire        external_count_pin, // External count clock pin.
	input  wire        capture_input_pin,  // Capture trigger pin.
	output reg         compare_pin_a,      // Compare output pin A.
	output reg         compare_pin_b,      // Compare output pin B.
	output reg         capture_irq,        // Capture interrupt request.
	output reg         match_a_irq,        // Match A interrupt request.
	output reg         match_b_irq,        // Match B interrupt request.
	output reg         wrap_irq            // Wrap interrupt request.
);

	////////////////////////////////////////////////////////////////////////////////
	// Storage.

	reg  [7:0]  timer_control_r;        // Enables and count source select.
	reg  [7:0]  timer_flags_register_r; // Flags, levels, edge and clear select.
	reg  [15:0] free_count_r;           // The free-running counter.
	reg  [15:0] compare_value_a_r;      // Compare register A.
	reg  [15:0] compare_value_b_r;      // Compare register B.
	reg  [15:0] capture_value_r;        // Capture register, read-only.
	reg  [7:0]  stage_r;                // Byte staging latch shared by all words.
	reg  [3:0]  flag_seen_r;            // Flags read as one, armed for clearing.
	reg  [4:0]  prescale_r;             // Internal divider for the count pulse.
	wire        ext_rise;               // Settled rising edge of the count pin.
	wire        cap_rise;               // Settled rising edge of the capture pin.
	wire        cap_fall;               // Settled falling edge of the capture pin.

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	frtcc_sync u_ext_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.pin_in (external_count_pin),
		.rise_r (ext_rise),
		.fall_r ()
	);

	frtcc_sync u_cap_sync (
		.clk    (clk),
		.arst_n (arst_n),
		.pin_in (capture_input_pin),
		.rise_r (cap_rise),
		.fall_r (cap_fall)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Combinational event decode.

	wire [1:0] src_sel = timer_control_r[1:0]; // Count source select field.
	reg        tick;                            // One count step this cycle.
	wire       cnt_wr  = wr_en & (addr == `FRTCC_A_CNT_L);    // Counter load from latch.
	wire       match_a = (free_count_r == compare_value_a_r); // (RULE4)
	wire       match_b = (free_count_r == compare_value_b_r); // (RULE4)
	// A processor load in the same cycle replaces the step, so it is no wrap.
	wire       wrap_ev = tick & ~cnt_wr & (free_count_r == 16'hffff); // (RULE2)
	wire       cap_ev;                                        // Selected capture edge.

	// Edge select 0 picks falling, 1 picks rising.
	assign cap_ev = timer_flags_register_r[`FRTCC_B_EDGE] ? cap_rise : cap_fall; // (RULE10) (RULE23)

	// Pick the divider terminal count or the pin edge as the count pulse.
	always @* begin
		case (src_sel)
			2'b00:   tick = ({4'h0, prescale_r[0]} == `FRTCC_DIV2_LAST);    // (RULE18)
			2'b01:   tick = ({2'b00, prescale_r[2:0]} == `FRTCC_DIV8_LAST); // (RULE18)
			2'b10:   tick = (prescale_r == `FRTCC_DIV32_LAST);             // (RULE18)
			default: tick = ext_rise;                                      // (RULE19)
		endcase
	end

	// Divider runs freely; the chosen tap fires once per divided period.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prescale_r <= 5'h00;
		end else if (standby) begin
			prescale_r <= 5'h00;
		end else begin
			prescale_r <= prescale_r + 5'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counter and capture register.

	// A processor load wins over counting; clear on match A comes next.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			free_count_r <= `FRTCC_CNT_RST; // (RULE3)
		end else if (standby) begin
			free_count_r <= `FRTCC_CNT_RST; // (RULE3)
		end else if (cnt_wr) begin
			free_count_r <= {stage_r, wdata}; // (RULE8) (RULE20)
		end else if (match_a & timer_flags_register_r[`FRTCC_B_CLRA]) begin
			free_count_r <= 16'h0000;
		end else if (tick) begin
			free_count_r <= free_count_r + 16'h0001; // (RULE1)
		end
	end

	// Every selected edge overwrites the capture, whatever the flag shows.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_value_r <= `FRTCC_CAP_RST; // (RULE13)
		end else if (standby) begin
			capture_value_r <= `FRTCC_CAP_RST; // (RULE13)
		end else if (cap_ev) begin
			capture_value_r <= free_count_r; // (RULE9) (RULE14)
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control and compare registers.

	// Word writes land only on the lower-byte strobe so both bytes change at once.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_control_r   <= `FRTCC_CTRL_RST; // (RULE15)
			compare_value_a_r <= `FRTCC_CMP_RST;  // (RULE7)
			compare_value_b_r <= `FRTCC_CMP_RST;  // (RULE7)
		end else if (standby) begin
			timer_control_r   <= `FRTCC_CTRL_RST; // (RULE15)
			compare_value_a_r <= `FRTCC_CMP_RST;  // (RULE7)
			compare_value_b_r <= `FRTCC_CMP_RST;  // (RULE7)
		end else if (wr_en) begin
			case (addr)
				`FRTCC_A_CTRL:   timer_control_r   <= wdata;
				`FRTCC_A_CMPA_L: compare_value_a_r <= {stage_r, wdata}; // (RULE8) (RULE20)
				`FRTCC_A_CMPB_L: compare_value_b_r <= {stage_r, wdata}; // (RULE8) (RULE20)
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Staging latch.

	// Upper-byte writes park data; counter and capture upper-byte reads park the low half.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stage_r <= 8'h00;
		end else if (wr_en) begin
			case (addr)
				`FRTCC_A_CNT_H, `FRTCC_A_CMPA_H, `FRTCC_A_CMPB_H: stage_r <= wdata; // (RULE20)
				default: ;
			endcase
		end else if (rd_en) begin
			case (addr)
				`FRTCC_A_CNT_H: stage_r <= free_count_r[7:0];    // (RULE8) (RULE21)
				`FRTCC_A_CAP_H: stage_r <= capture_value_r[7:0]; // (RULE11) (RULE21)
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags register.

	wire [3:0] flag_set = {cap_ev, match_b, match_a, wrap_ev}; // Hardware set events.
	wire       flags_wr = wr_en & (addr == `FRTCC_A_FLAGS);     // Software write.
	wire [3:0] flag_clr;                                        // Armed flags written 0.
	genvar     g;                                               // Bit loop index.

	// A flag clears only if it was read as one and is now written zero.
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_clr
			assign flag_clr[g] = flags_wr & flag_seen_r[g] & ~wdata[g + 4]; // (RULE22)
		end
	endgenerate

	// Set beats clear so an event in the clearing cycle is not lost.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_flags_register_r <= `FRTCC_FLAGS_RST;
			flag_seen_r            <= 4'h0;
		end else if (standby) begin
			timer_flags_register_r <= `FRTCC_FLAGS_RST;
			flag_seen_r            <= 4'h0;
		end else begin
			timer_flags_register_r[7:4] <= (timer_flags_register_r[7:4] & ~flag_clr)
				| flag_set; // (RULE2) (RULE4) (RULE9) (RULE22)
			if (flags_wr) begin
				timer_flags_register_r[3:0] <= wdata[3:0];
			end
			if (rd_en & (addr == `FRTCC_A_FLAGS)) begin
				flag_seen_r <= timer_flags_register_r[7:4]; // (RULE22)
			end else if (flags_wr) begin
				flag_seen_r <= 4'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data.

	// Compare registers read straight; counter and capture low bytes read the latch.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				`FRTCC_A_CTRL:   rdata_r <= timer_control_r;
				`FRTCC_A_FLAGS:  rdata_r <= timer_flags_register_r;
				`FRTCC_A_CNT_H:  rdata_r <= free_count_r[15:8];
				`FRTCC_A_CNT_L:  rdata_r <= stage_r;                  // (RULE21)
				`FRTCC_A_CMPA_H: rdata_r <= compare_value_a_r[15:8];  // (RULE21)
				`FRTCC_A_CMPA_L: rdata_r <= compare_value_a_r[7:0];   // (RULE21)
				`FRTCC_A_CMPB_H: rdata_r <= compare_value_b_r[15:8];
				`FRTCC_A_CMPB_L: rdata_r <= compare_value_b_r[7:0];
				`FRTCC_A_CAP_H:  rdata_r <= capture_value_r[15:8];
				`FRTCC_A_CAP_L:  rdata_r <= stage_r;                  // (RULE11)
				default:         rdata_r <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare pins and interrupt requests.

	// Pins hold zero from reset; only an enabled match moves them.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			compare_pin_a <= 1'b0; // (RULE6)
			compare_pin_b <= 1'b0; // (RULE6)
		end else begin
			if (match_a & timer_control_r[`FRTCC_B_PIN_A]) begin
				compare_pin_a <= timer_flags_register_r[`FRTCC_B_LVL_A]; // (RULE5) (RULE17)
			end
			if (match_b & timer_control_r[`FRTCC_B_PIN_B]) begin
				compare_pin_b <= timer_flags_register_r[`FRTCC_B_LVL_B]; // (RULE5) (RULE17)
			end
		end
	end

	// Requests are registered levels, one cycle behind flag or enable changes.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			capture_irq <= 1'b0;
			match_b_irq <= 1'b0;
			match_a_irq <= 1'b0;
			wrap_irq    <= 1'b0;
		end else begin
			capture_irq <= timer_control_r[`FRTCC_B_CAP_IE]
				& timer_flags_register_r[`FRTCC_B_CAPF]; // (RULE16) (RULE24)
			match_b_irq <= timer_control_r[`FRTCC_B_MB_IE]
				& timer_flags_register_r[`FRTCC_B_MBF]; // (RULE16) (RULE24)
			match_a_irq <= timer_control_r[`FRTCC_B_MA_IE]
				& timer_flags_register_r[`FRTCC_B_MAF]; // (RULE16) (RULE24)
			wrap_irq    <= timer_control_r[`FRTCC_B_WRAP_IE]
				& timer_flags_register_r[`FRTCC_B_WRAPF]; // (RULE16) (RULE24)
		end
	end

endmodule // frtcc_timer

// [frtcc_defs.vh]
// Constants for the free-running timer with compare and capture channels.
// What this block does
// (RULE1) 16-bit up-counter stepped by selected source pulse
// (RULE2) Wrap from all ones sets wrap flag
// (RULE3) Counter cleared on reset and standby
// (RULE4) Compare registers matched continuously, set match flags
// (RULE5) Enabled match drives pin to level bit
// (RULE6) Compare pins low after reset until match
// (RULE7) Compare registers set all ones on reset/standby
// (RULE8) Counter and compare writes go through latch
// (RULE9) Capture edge copies counter, sets capture flag
// (RULE10) Capture edge chosen by edge select bit
// (RULE11) Capture register read through staging latch
// (RULE12) Capture pulses held at least 1.5 cycles
// (RULE13) Capture register cleared on reset/standby
// (RULE14) Capture overwrites even when flag still set
// (RULE15) Control register cleared on reset/standby
// (RULE16) Control bits 7..4 enable four interrupt requests
// (RULE17) Control bits 3,2 enable compare pins B,A
// (RULE18) Source select: /2, /8, /32, external pin
// (RULE19) External source counts rising pin edges
// (RULE20) Upper write latched, lower write loads both
// (RULE21) Upper read latches low; compares read directly
// (RULE22) Flags cleared by read-one then write-zero
// (RULE23) Edge select 0 falling, 1 rising
// (RULE24) Interrupt request follows flag and enable
`ifndef FRTCC_DEFS_VH
`define FRTCC_DEFS_VH
`define FRTCC_A_CTRL    16'hff90
`define FRTCC_A_FLAGS   16'hff91
`define FRTCC_A_CNT_H   16'hff92
`define FRTCC_A_CNT_L   16'hff93
`define FRTCC_A_CMPA_H  16'hff94
`define FRTCC_A_CMPA_L  16'hff95
`define FRTCC_A_CMPB_H  16'hff96
`define FRTCC_A_CMPB_L  16'hff97
`define FRTCC_A_CAP_H   16'hff98
`define FRTCC_A_CAP_L   16'hff99
`define FRTCC_CTRL_RST  8'h00
`define FRTCC_FLAGS_RST 8'h00
`define FRTCC_CNT_RST   16'h0000
`define FRTCC_CMP_RST   16'hffff
`define FRTCC_CAP_RST   16'h0000
`define FRTCC_B_CAP_IE  7
`define FRTCC_B_MB_IE   6
`define FRTCC_B_MA_IE   5
`define FRTCC_B_WRAP_IE 4
`define FRTCC_B_PIN_B   3
`define FRTCC_B_PIN_A   2
`define FRTCC_B_CAPF    7
`define FRTCC_B_MBF     6
`define FRTCC_B_MAF     5
`define FRTCC_B_WRAPF   4
`define FRTCC_B_LVL_B   3
`define FRTCC_B_LVL_A   2
`define FRTCC_B_EDGE    1
`define FRTCC_B_CLRA    0
`define FRTCC_FLAG_MASK 8'hf0
`define FRTCC_DIV2_LAST  5'h01
`define FRTCC_DIV8_LAST  5'h07
`define FRTCC_DIV32_LAST 5'h1f
`endif

// [frtcc_sync.v]
// Two-flop synchroniser with an edge detector on the settled side.
module frtcc_sync (
	input  wire clk,    // System clock.
	input  wire arst_n, // Asynchronous reset, active low.
	input  wire pin_in, // Raw pin from outside the clock domain.
	output reg  rise_r, // One-cycle pulse on a settled rising edge.
	output reg  fall_r  // One-cycle pulse on a settled falling edge.
);
	reg meta_r;   // First stage, read only by the second stage.
	reg stable_r; // Second stage.
	reg prev_r;   // Previous settled level for edge detection.

	// The edge detector reads only the second and third stages, never the first.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_r   <= 1'b0;
			stable_r <= 1'b0;
			prev_r   <= 1'b0;
			rise_r   <= 1'b0;
			fall_r   <= 1'b0;
		end else begin
			meta_r   <= pin_in;
			stable_r <= meta_r;
			prev_r   <= stable_r;
			rise_r   <= stable_r & ~prev_r;
			fall_r   <= ~stable_r & prev_r;
		end
	end
endmodule // frtcc_sync

// [frtcc_monitor.sv]
// Port-level checker for the free-running timer, with its bind.
module frtcc_monitor (
	input wire        clk,           // System clock.
	input wire        arst_n,        // Reset, active low.
	input wire        standby,       // Standby request.
	input wire [15:0] addr,          // Bus address.
	input wire        rd_en,         // Read strobe.
	input wire        wr_en,         // Write strobe.
	input wire [7:0]  wdata,         // Write byte.
	input wire [7:0]  rdata_r,       // Read byte.
	input wire        compare_pin_a, // Pin A.
	input wire        compare_pin_b, // Pin B.
	input wire        capture_irq,   // Capture request.
	input wire        match_a_irq,   // Match A request.
	input wire        match_b_irq,   // Match B request.
	input wire        wrap_irq       // Wrap request.
);
	// High when no request is raised.
	wire quiet = !(capture_irq || match_a_irq || match_b_irq || wrap_irq);
	// A write to the control byte.
	wire ctl_wr = wr_en && (addr == 16'hff90);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////////////////////
	property p_pins_low; $rose(arst_n) |-> !compare_pin_a && !compare_pin_b; endproperty
	a_pins_low: assert property (p_pins_low) else $error("pin high after reset");
	property p_irq_rst; $rose(arst_n) |-> quiet; endproperty
	a_irq_rst: assert property (p_irq_rst) else $error("request after reset");
	property p_rd_hold; !rd_en |=> $stable(rdata_r); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read byte moved");
	property p_sby_quiet; standby |-> ##2 quiet; endproperty
	a_sby_quiet: assert property (p_sby_quiet) else $error("request in standby");
	property p_mask_cap; ctl_wr && !wdata[7] |-> ##2 !capture_irq; endproperty
	a_mask_cap: assert property (p_mask_cap) else $error("capture not masked");
	property p_mask_all; ctl_wr && (wdata[7:4] == 4'h0) |-> ##2 quiet; endproperty
	a_mask_all: assert property (p_mask_all) else $error("request not masked");
	// Without a write or standby nothing can clear a flag, so requests hold.
	property p_hold_cap;
		capture_irq && !wr_en && !$past(wr_en) && !standby && !$past(standby) |=> capture_irq;
	endproperty
	a_hold_cap: assert property (p_hold_cap) else $error("capture request lost");
	property p_hold_wrap;
		wrap_irq && !wr_en && !$past(wr_en) && !standby && !$past(standby) |=> wrap_irq;
	endproperty
	a_hold_wrap: assert property (p_hold_wrap) else $error("wrap request lost");
	property p_sby_pins;
		standby ##1 standby |=> $stable(compare_pin_a) && $stable(compare_pin_b);
	endproperty
	a_sby_pins: assert property (p_sby_pins) else $error("pin moved in standby");
endmodule // frtcc_monitor

bind frtcc_timer frtcc_monitor u_mon (.clk(clk), .arst_n(arst_n), .standby(standby),
	.addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wdata(wdata), .rdata_r(rdata_r),
	.compare_pin_a(compare_pin_a), .compare_pin_b(compare_pin_b), .capture_irq(capture_irq),
	.match_a_irq(match_a_irq), .match_b_irq(match_b_irq), .wrap_irq(wrap_irq));

// [frtcc_cpu.sv]
// Processor model that drives the timer's byte bus.
module frtcc_cpu (
	input  wire        clk,    // System clock.
	output reg  [15:0] addr,   // Byte address.
	output reg         rd_en,  // Read strobe.
	output reg         wr_en,  // Write strobe.
	output reg  [7:0]  wdata,  // Write byte.
	input  wire [7:0]  rdata_r // Read byte.
);
	timeunit 1ns;
	timeprecision 100ps;
	// Bus idles from time zero.
	initial begin
		addr = 16'h0000;
		rd_en = 1'b0;
		wr_en = 1'b0;
		wdata = 8'h00;
	end
	// One byte write; after release the data is inverted so no stale byte looks valid.
	task wr(input [15:0] a, input [7:0] d);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(posedge clk) #1 wr_en = 1'b0;
		wdata = ~d;
		@(posedge clk) #1;
	endtask
	// One byte read; the byte is taken just after the sampling edge.
	task rd(input [15:0] a, output [7:0] d);
		addr = a;
		rd_en = 1'b1;
		@(posedge clk) #1 rd_en = 1'b0;
		d = rdata_r;
		addr = ~a;
		@(posedge clk) #1;
	endtask
	// Word write, upper byte first so the staging latch pairs them.
	task wr16(input [15:0] a, input [15:0] v);
		wr(a, v[15:8]);
		wr(a + 16'h0001, v[7:0]);
	endtask
	// Word read, upper byte first.
	task rd16(input [15:0] a, output [15:0] v);
		rd(a, v[15:8]);
		rd(a + 16'h0001, v[7:0]);
	endtask
	// Flag clearing: read the flags while set, then write zero to the chosen bits.
	task clr(input [7:0] m);
		reg [7:0] f;
		rd(16'hff91, f);
		wr(16'hff91, f & ~m);
	endtask
endmodule // frtcc_cpu

// [free_running_timer_capture_compare_tb.sv]
// Self-checking bench for the free-running timer.
module free_running_timer_capture_compare_tb;
	timeunit 1ns;
	timeprecision 100ps;
	reg         clk, arst_n, standby, xp, cp; // Clock, reset and pins.
	wire [15:0] addr;                         // Bus address.
	wire        rd_en, wr_en;                 // Strobes.
	wire [7:0]  wdata, rdata_r;               // Data bytes.
	wire        pa, pb, ci, mai, mbi, wi;     // Pins and requests.
	integer     failures, num_checks, cyc, s; // Counters.
	reg  [15:0] v;                            // Word read back.
	reg  [7:0]  b;                            // Byte read back.
	frtcc_timer dut (.clk(clk), .arst_n(arst_n), .standby(standby), .addr(addr),
		.rd_en(rd_en), .wr_en(wr_en), .wdata(wdata), .rdata_r(rdata_r),
		.external_count_pin(xp), .capture_input_pin(cp), .compare_pin_a(pa),
		.compare_pin_b(pb), .capture_irq(ci), .match_a_irq(mai), .match_b_irq(mbi),
		.wrap_irq(wi));
	frtcc_cpu cpu (.clk(clk), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
		.wdata(wdata), .rdata_r(rdata_r));
	////////////////////////////////////////////////////////////////
	// 50 MHz clock.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Compare and count; a mismatch is reported at once.
	task check(input [15:0] seen, input [15:0] exp);
		num_checks = num_checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Cuts a hang short; the run needs about 3000 cycles.
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 10000) begin
			failures = failures + 1;
			give_verdict;
		end
	end
	task tick(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// External count pulses, two cycles each way, then time for the synchroniser.
	task ext(input integer n);
		repeat (n) begin
			xp = 1'b1;
			tick(2);
			xp = 1'b0;
			tick(2);
		end
		tick(4);
	endtask
	// Capture pin level held six cycles, well beyond the minimum width.
	task cap(input l);
		cp = l;
		tick(6);
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset;
		cpu.rd(16'hff90, b); check(b, 8'h00);
		cpu.rd16(16'hff94, v); check(v, 16'hffff);
		cpu.rd16(16'hff96, v); check(v, 16'hffff);
		cpu.rd16(16'hff98, v); check(v, 16'h0000);
		cpu.rd(16'hff9a, b); check(b, 8'h00);
	endtask
	// Counter held on the idle external pin, so reads are exact.
	task t_latch;
		cpu.wr(16'hff90, 8'h03); cpu.wr16(16'hff92, 16'h1234);
		cpu.rd16(16'hff92, v); check(v, 16'h1234);
		ext(3); cpu.rd16(16'hff92, v); check(v, 16'h1237);
		cpu.wr(16'hff94, 8'haa); cpu.rd16(16'hff94, v); check(v, 16'hffff);
		cpu.wr(16'hff95, 8'h55); cpu.rd16(16'hff94, v); check(v, 16'haa55);
	endtask
	task t_capture;
		cpu.wr(16'hff90, 8'h83); cpu.wr(16'hff91, 8'h02); cap(1'b1);
		cpu.rd16(16'hff98, v); check(v, 16'h1237);
		check(ci, 1'b1); cpu.rd(16'hff91, b); check(b, 8'h82);
		ext(2); cap(1'b0); cap(1'b1);
		cpu.rd16(16'hff98, v); check(v, 16'h1239);
		cpu.clr(8'h80); cpu.rd(16'hff91, b); check(b, 8'h02);
		check(ci, 1'b0); cpu.wr(16'hff91, 8'hf2);
		cpu.rd(16'hff91, b); check(b, 8'h02);
		cpu.wr(16'hff91, 8'h00); ext(1); cap(1'b0);
		cpu.rd16(16'hff98, v); check(v, 16'h123a);
	endtask
	// Both channels match; only A may drive its pin.
	task t_match;
		cpu.wr16(16'hff92, 16'h0010); cpu.wr16(16'hff94, 16'h0011);
		cpu.wr16(16'hff96, 16'h0011); cpu.wr(16'hff91, 8'h0c); cpu.wr(16'hff90, 8'h27);
		check(pa, 1'b0); ext(1); check(pa, 1'b1); check(pb, 1'b0);
		check(mai, 1'b1); check(mbi, 1'b0);
		cpu.rd(16'hff91, b); check(b, 8'hec);
		cpu.wr(16'hff90, 8'h07); check(mai, 1'b0);
		cpu.wr16(16'hff92, 16'hffff); cpu.wr(16'hff90, 8'h13); ext(1);
		check(wi, 1'b1); cpu.rd(16'hff91, b); check(b, 8'hfc);
	endtask
	// Each divided source gives about 64 steps in 64 of its periods.
	task t_div;
		for (s = 0; s < 3; s = s + 1) begin
			cpu.wr(16'hff90, s[7:0]); cpu.wr16(16'hff92, 16'h0000);
			tick(64 * (2 << (2 * s))); cpu.rd16(16'hff92, v);
			check({15'h0000, v >= 16'd63 && v <= 16'd67}, 16'h0001);
		end
	endtask
	// Clear on match A, pin B driven by its own match, pin A left alone while disabled.
	task t_clear;
		cpu.wr(16'hff90, 8'h4b); check(mbi, 1'b1);
		cpu.wr16(16'hff96, 16'h0002); cpu.wr16(16'hff94, 16'h0003);
		cpu.wr16(16'hff92, 16'h0000); cpu.wr(16'hff91, 8'h09);
		check(pb, 1'b0);
		check(mbi, 1'b0);
		ext(3); check(pb, 1'b1);
		check(mbi, 1'b1);
		check(pa, 1'b1);
		cpu.rd16(16'hff92, v); check(v, 16'h0000);
		cpu.rd(16'hff91, b); check(b, 8'h69);
	endtask
	task t_standby;
		standby = 1'b1; tick(2); standby = 1'b0;
		cpu.rd(16'hff90, b); check(b, 8'h00);
		cpu.rd16(16'hff94, v); check(v, 16'hffff);
		cpu.rd16(16'hff98, v); check(v, 16'h0000);
		cpu.rd16(16'hff92, v); check({15'h0000, v < 16'h0010}, 16'h0001);
	endtask
	// Main sequence: reset held 16 cycles, then each scenario in turn.
	initial begin
		failures = 0; num_checks = 0; cyc = 0;
		arst_n = 1'b0; standby = 1'b0; xp = 1'b0; cp = 1'b0;
		repeat (16) @(posedge clk);
		#1 arst_n = 1'b1;
		t_reset; t_latch; t_capture; t_match; t_div; t_clear; t_standby;
		give_verdict;
	end
endmodule // free_running_timer_capture_compare_tb
